// [design/edge_sync.sv]
// Two-flop synchroniser with rising and falling edge pulses
`default_nettype none
module edge_sync (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic async_in,
  output logic      level_q,
  output logic      rise_q,
  output logic      fall_q
);
  logic meta_q;
  logic sync_q;

  // Synchroniser chain; first flop read only by the second
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q  <= 1'b1;
      sync_q  <= 1'b1;
      level_q <= 1'b1;
    end else begin
      meta_q  <= async_in;
      sync_q  <= meta_q;
      level_q <= sync_q;
    end
  end

  // Edge pulses from the settled level
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rise_q <= sync_q & ~level_q;
      fall_q <= ~sync_q & level_q;
    end
  end
endmodule // edge_sync
`default_nettype wire

// [design/twi_event_flags.sv]
// Event flags, shortcut links, interrupt enables and suspend sequencing of the two-wire master
//
// Local design decision: strobed register access.
`default_nettype none
module twi_event_flags
  import twi_flags_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          reset_n,
  input  wire reg_req_t      req,
  output logic [DATA_W-1:0]  rdata_q,
  input  wire engine_evt_t   evt,
  input  wire logic          scl_in,
  input  wire logic          read_mode,
  output logic               suspend_req_q,
  output logic               stop_req_q,
  output logic               held_q,
  output logic               irq_q
);
  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_ARMED   = 2'b01,
    ST_HELD    = 2'b10
  } pause_state_t;

  pause_state_t        state_q;
  logic [NUM_EV-1:0]   flags_q;
  logic [NUM_EV-1:0]   ev_set;
  logic [NUM_EV-1:0]   irq_en_q;
  logic [1:0]          links_q;
  logic                scl_fall;
  logic                ack_pending_q;
  logic                ack_done;
  logic [2:0]          widx;
  logic                wr_suspend;
  logic                wr_resume;
  logic                wr_stop;

  // Link clock sampled through two flops; only the falling edge times the acknowledge
  edge_sync u_scl_sync (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .async_in (scl_in),
    .level_q  (),
    .rise_q   (),
    .fall_q   (scl_fall)
  );

  // Task strobes decoded from register writes
  assign widx       = flag_index(req.addr);
  assign wr_suspend = req.wr && req.addr == OFS_SUSPEND && req.wdata[0];
  assign wr_resume  = req.wr && req.addr == OFS_RESUME && req.wdata[0];
  assign wr_stop    = req.wr && req.addr == OFS_STOP && req.wdata[0];

  // The acknowledge bit ends at the first clock fall after the engine reports it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_pending_q <= 1'b0;
    end else if (evt.read_ack_done) begin
      ack_pending_q <= 1'b1;
    end else if (scl_fall) begin
      ack_pending_q <= 1'b0;
    end
  end
  assign ack_done = ack_pending_q & scl_fall & read_mode;

  // Suspend sequencing: request arms, pause taken only after a read acknowledge
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (wr_suspend || (evt.byte_start && links_q[LINK_PAUSE_BIT])) begin
            state_q <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (wr_resume || evt.stopped) begin
            state_q <= ST_RUN;
          end else if (ack_done) begin
            state_q <= ST_HELD;
          end
        end
        ST_HELD: begin
          if (wr_resume || evt.stopped) begin
            state_q <= ST_RUN;
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // Event sources
  always_comb begin
    ev_set               = '0;
    ev_set[EV_STOPPED]   = evt.stopped;
    ev_set[EV_RX_BYTE]   = evt.rx_done;
    ev_set[EV_TX_BYTE]   = evt.tx_done;
    ev_set[EV_BUS_FAULT] = evt.fault;
    ev_set[EV_BYTE_EDGE] = evt.byte_start;
    ev_set[EV_PAUSED]    = (state_q == ST_ARMED) && ack_done && !wr_resume && !evt.stopped;
  end

  // Sticky flags: writing 0 clears, a same-cycle event wins
  generate
    for (genvar i = 0; i < NUM_EV; i++) begin : g_flag
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          flags_q[i] <= FLAGS_RESET[i];
        end else if (ev_set[i]) begin
          flags_q[i] <= 1'b1;
        end else if (req.wr && widx == 3'(i)) begin
          flags_q[i] <= req.wdata[0];
        end
      end
    end
  endgenerate

  // Shortcut links and interrupt enables
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      links_q  <= LINKS_RESET;
      irq_en_q <= IRQ_EN_RESET;
    end else begin
      if (req.wr && req.addr == OFS_LINKS) begin
        links_q <= req.wdata[1:0];
      end
      if (req.wr && req.addr == OFS_IRQ_SET) begin
        irq_en_q <= irq_en_q | req.wdata[NUM_EV-1:0];
      end else if (req.wr && req.addr == OFS_IRQ_CLR) begin
        irq_en_q <= irq_en_q & ~req.wdata[NUM_EV-1:0];
      end
    end
  end

  // Task pulses and the held level towards the bus engine
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      suspend_req_q <= 1'b0;
      stop_req_q    <= 1'b0;
      held_q        <= 1'b0;
    end else begin
      suspend_req_q <= wr_suspend || (evt.byte_start && links_q[LINK_PAUSE_BIT]);
      stop_req_q    <= wr_stop || (evt.byte_start && links_q[LINK_HALT_BIT]);
      held_q        <= (state_q == ST_HELD) || ev_set[EV_PAUSED];
    end
  end

  // Level interrupt from enabled flags
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flags_q & irq_en_q);
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= '0;
    end else if (req.rd) begin
      rdata_q <= '0;
      if (widx != 3'(NUM_EV)) begin
        rdata_q[0] <= flags_q[widx];
      end else if (req.addr == OFS_LINKS) begin
        rdata_q[1:0] <= links_q;
      end else if (req.addr == OFS_IRQ_SET || req.addr == OFS_IRQ_CLR) begin
        rdata_q[NUM_EV-1:0] <= irq_en_q;
      end
    end else begin
      rdata_q <= '0;
    end
  end

endmodule // twi_event_flags
`default_nettype wire

// [design/twi_flags_pkg.sv]
// Package of register map, field layout and timing constants for the event flag block
//
// Contract
// - Separate flags set on byte received, byte sent and bus error.
// - Byte-boundary event raised before every byte sent or received.
// - Paused flag sets when the transaction is paused on a suspend request.
// - Pause fires right after a read acknowledge, only if suspend was requested.
// - Link bit 0 turns byte-boundary into suspend, bit 1 into stop.
// - Writing 1 to an enable-set bit enables that interrupt; reads show state.
`default_nettype none
package twi_flags_pkg;
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;
  localparam int          NUM_EV          = 6;
  localparam logic [11:0] OFS_STOPPED     = 12'h104;
  localparam logic [11:0] OFS_RX_BYTE     = 12'h108;
  localparam logic [11:0] OFS_TX_BYTE     = 12'h11C;
  localparam logic [11:0] OFS_BUS_FAULT   = 12'h124;
  localparam logic [11:0] OFS_BYTE_EDGE   = 12'h138;
  localparam logic [11:0] OFS_PAUSED      = 12'h148;
  localparam logic [11:0] OFS_LINKS       = 12'h200;
  localparam logic [11:0] OFS_IRQ_SET     = 12'h304;
  localparam logic [11:0] OFS_IRQ_CLR     = 12'h308;
  localparam logic [11:0] OFS_SUSPEND     = 12'h01C;
  localparam logic [11:0] OFS_RESUME      = 12'h020;
  localparam logic [11:0] OFS_STOP        = 12'h014;
  // Event bit positions, shared by flags and interrupt enables
  localparam int          EV_STOPPED      = 0;
  localparam int          EV_RX_BYTE      = 1;
  localparam int          EV_TX_BYTE      = 2;
  localparam int          EV_BUS_FAULT    = 3;
  localparam int          EV_BYTE_EDGE    = 4;
  localparam int          EV_PAUSED       = 5;
  localparam int          LINK_PAUSE_BIT  = 0;
  localparam int          LINK_HALT_BIT   = 1;
  localparam logic [1:0]  LINKS_RESET     = 2'h0;
  localparam logic [5:0]  IRQ_EN_RESET    = 6'h00;
  localparam logic [5:0]  FLAGS_RESET     = 6'h00;
  // Link clock edge filter
  localparam int          SYS_CLK_NS      = 8;
  localparam int          SCL_PERIOD_NS   = 125;
  localparam int          SCL_CYC         = SCL_PERIOD_NS / SYS_CLK_NS;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  // Bus engine status pulses
  typedef struct packed {
    logic rx_done;
    logic tx_done;
    logic fault;
    logic byte_start;
    logic read_ack_done;
    logic stopped;
  } engine_evt_t;

  // Offset to event index; returns NUM_EV if not a flag register
  function automatic logic [2:0] flag_index(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_STOPPED:   flag_index = 3'(EV_STOPPED);
      OFS_RX_BYTE:   flag_index = 3'(EV_RX_BYTE);
      OFS_TX_BYTE:   flag_index = 3'(EV_TX_BYTE);
      OFS_BUS_FAULT: flag_index = 3'(EV_BUS_FAULT);
      OFS_BYTE_EDGE: flag_index = 3'(EV_BYTE_EDGE);
      OFS_PAUSED:    flag_index = 3'(EV_PAUSED);
      default:       flag_index = 3'(NUM_EV);
    endcase
  endfunction
endpackage : twi_flags_pkg
`default_nettype wire

// [tb/twi_bus_model.sv]
// Far-side clock source: link clock runs only within frames
`default_nettype none
module twi_bus_model (
  input  wire logic run,
  output var logic  scl
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up holds the idle line high between frames
  initial begin
    scl = 1'b1;
    forever begin
      #62.5;
      scl = run ? ~scl : 1'b1;
    end
  end
endmodule // twi_bus_model
`default_nettype wire

// [tb/twi_event_flags_tb.sv]
// Testbench for the event flag block
`default_nettype none
module twi_event_flags_tb
  import twi_flags_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              sys_clk = 1'b0;
  logic              reset_n = 1'b0;
  reg_req_t          req = '0;
  engine_evt_t       evt = '0;
  logic              read_mode = 1'b0;
  logic              scl_run = 1'b0;
  logic              scl_in;
  logic [DATA_W-1:0] rdata_q;
  logic              suspend_req_q;
  logic              stop_req_q;
  logic              held_q;
  logic              irq_q;
  logic [31:0]       v;
  int                error_cnt = 0;
  int                checks = 0;
  logic [11:0]       ofs [6] = '{OFS_STOPPED, OFS_RX_BYTE, OFS_TX_BYTE, OFS_BUS_FAULT,
                                 OFS_BYTE_EDGE, OFS_PAUSED};
  // Clock, partner and design
  always #4 sys_clk = ~sys_clk;
  twi_bus_model u_bus (.run(scl_run), .scl(scl_in));
  twi_event_flags u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .req(req), .rdata_q(rdata_q),
    .evt(evt), .scl_in(scl_in), .read_mode(read_mode), .suspend_req_q(suspend_req_q),
    .stop_req_q(stop_req_q), .held_q(held_q), .irq_q(irq_q));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 v = rdata_q;
  endtask
  task automatic pulse(input engine_evt_t e);
    @(posedge sys_clk);
    evt <= e;
    @(posedge sys_clk);
    evt <= '0;
    #1;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Read ack with link clock running; pause only when armed
  task automatic ack_frame(input logic [31:0] exp);
    pulse('{read_ack_done: 1'b1, default: 1'b0});
    scl_run = 1'b1;
    settle(40);
    scl_run = 1'b0;
    rd(OFS_PAUSED);
    check(v, exp);
    check(held_q, exp);
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    foreach (ofs[i]) begin
      rd(ofs[i]);
      check(v, 32'h0);
    end
    rd(OFS_IRQ_SET);
    check(v, 32'h0);
    pulse('{rx_done: 1'b1, tx_done: 1'b1, fault: 1'b1, default: 1'b0});
    for (int i = 1; i < 4; i++) begin
      rd(ofs[i]);
      check(v, 32'h1);
      wr(ofs[i], 32'h0);
      rd(ofs[i]);
      check(v, 32'h0);
    end
    @(posedge sys_clk);
    read_mode <= 1'b1;
    ack_frame(32'h0);
    // Suspend task pulse stands for the cycle after the write
    wr(OFS_SUSPEND, 32'h1);
    settle(0);
    check(suspend_req_q, 1'b1);
    ack_frame(32'h1);
    wr(OFS_RESUME, 32'h1);
    settle(2);
    check(held_q, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_LINKS, 32'(i));
      pulse('{byte_start: 1'b1, default: 1'b0});
      check({stop_req_q, suspend_req_q}, 32'(i));
    end
    // Flag read right behind the byte edge, so the checker sees the flag path too
    rd(OFS_BYTE_EDGE);
    check(v, 32'h1);
    rd(OFS_LINKS);
    check(v, 32'h3);
    // Stop task pulse, then the engine reports the stop
    wr(OFS_STOP, 32'h1);
    settle(0);
    check(stop_req_q, 1'b1);
    pulse('{stopped: 1'b1, default: 1'b0});
    rd(OFS_STOPPED);
    check(v, 32'h1);
    wr(OFS_IRQ_SET, 32'h3F);
    wr(OFS_IRQ_CLR, 32'h2D);
    rd(OFS_IRQ_SET);
    check(v, 32'h12);
    wr(OFS_BYTE_EDGE, 32'h0);
    settle(2);
    check(irq_q, 1'b0);
    pulse('{rx_done: 1'b1, default: 1'b0});
    settle(1);
    check(irq_q, 1'b1);
    wr(OFS_IRQ_CLR, 32'h12);
    settle(2);
    check(irq_q, 1'b0);
    // Mid-run reset returns a set flag to zero
    reset_n <= 1'b0;
    settle(3);
    reset_n <= 1'b1;
    rd(OFS_PAUSED);
    check(v, 32'h0);
    print_verdict();
  end
  // Watchdog against a hang
  initial begin
    #50000;
    error_cnt++;
    print_verdict();
  end
endmodule // twi_event_flags_tb
`default_nettype wire

// [tb/twi_flags_checker.sv]
// Assertion checker for the event flag block
`default_nettype none
module twi_flags_checker
  import twi_flags_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire reg_req_t          req,
  input  wire logic [DATA_W-1:0] rdata_q,
  input  wire engine_evt_t       evt,
  input  wire logic              scl_in,
  input  wire logic              read_mode,
  input  wire logic              suspend_req_q,
  input  wire logic              stop_req_q,
  input  wire logic              held_q,
  input  wire logic              irq_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] links_q;
  logic [5:0] en_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Shadow copies of the link and enable registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      links_q <= LINKS_RESET;
      en_q    <= IRQ_EN_RESET;
    end else if (req.wr) begin
      if (req.addr == OFS_LINKS) links_q <= req.wdata[1:0];
      if (req.addr == OFS_IRQ_SET) en_q <= en_q | req.wdata[5:0];
      if (req.addr == OFS_IRQ_CLR) en_q <= en_q & ~req.wdata[5:0];
    end
  end
  a_rdata_idle: assert property (!$past(req.rd) |-> rdata_q == '0)
    else $error("read data not zero outside read slot");
  a_edge_pause: assert property (evt.byte_start && links_q[0] |=> suspend_req_q)
    else $error("byte edge did not request suspend");
  a_edge_halt: assert property (evt.byte_start && links_q[1] |=> stop_req_q)
    else $error("byte edge did not request stop");
  a_no_link: assert property (evt.byte_start && !links_q[0] && !req.wr |=> !suspend_req_q)
    else $error("suspend requested with link off");
  a_edge_flag: assert property (
    evt.byte_start ##1 !req.wr ##1 (req.rd && req.addr == OFS_BYTE_EDGE) |=> rdata_q[0])
    else $error("byte edge flag not set");
  a_stop_single: assert property (stop_req_q |=> !stop_req_q)
    else $error("stop request longer than one cycle");
  a_irq_masked: assert property (en_q == '0 && $past(en_q) == '0 |-> !irq_q)
    else $error("interrupt with all enables off");
  a_held_read: assert property ($rose(held_q) |-> $past(read_mode))
    else $error("bus held outside a read");
endmodule // twi_flags_checker
bind twi_event_flags twi_flags_checker u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .req(req), .rdata_q(rdata_q), .evt(evt),
  .scl_in(scl_in), .read_mode(read_mode), .suspend_req_q(suspend_req_q),
  .stop_req_q(stop_req_q), .held_q(held_q), .irq_q(irq_q));
`default_nettype wire
